// ---- common/pmx_pkg.sv ----
package pmx_pkg;
  // Clock and MII nibble rates.
  localparam int CLK_MHZ    = 250;
  localparam int CLK_KHZ    = 250000;
  localparam int MII100_KHZ = 25000;
  localparam int MII10_KHZ  = 2500;
  localparam logic [7:0] HALF_100 = 8'(CLK_KHZ / (2 * MII100_KHZ));
  localparam logic [7:0] HALF_10  = 8'(CLK_KHZ / (2 * MII10_KHZ));
  // Crossover hunt slot.
  localparam int SWAP_TIME_US = 100;
  localparam int SWAP_CYCLES  = SWAP_TIME_US * CLK_MHZ;
  // Heartbeat length after a 10M half-duplex frame, in nibble periods.
  localparam logic [3:0] SQE_NIBBLES = 4'ha;
  // Management frame fields.
  localparam logic [5:0] PRE_BITS  = 6'h20;
  localparam logic [4:0] HDR_BITS  = 5'h0d;
  localparam logic [4:0] DATA_BITS = 5'h10;
  localparam logic [1:0] OP_RD     = 2'h2;
  localparam logic [1:0] OP_WR     = 2'h1;
  localparam logic [4:0] PHY_ADDR_DEF = 5'h01;
  // Management register map.
  localparam logic [4:0] REG_XCTL  = 5'h13;
  localparam logic [4:0] REG_CSTAT = 5'h11;
  localparam int XCTL_AUTO_BIT = 8;
  localparam int XCTL_MAN_BIT  = 9;
  localparam logic [1:0] XCTL_RST = 2'h1;
  // Transmit buffer shape.
  localparam int NIB_W      = 4;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [2:0] {
    MD_PRE = 3'b000,
    MD_HDR = 3'b001,
    MD_TA  = 3'b010,
    MD_RD  = 3'b011,
    MD_WR  = 3'b100
  } pmx_md_st_t;

  typedef enum logic {
    XO_HUNT = 1'b0,
    XO_LOCK = 1'b1
  } pmx_xo_st_t;
endpackage

// ---- verilog/pmx_clkdiv.sv ----
`timescale 1ns/1ps
module pmx_clkdiv
  import pmx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] half_cycles,
  output logic            clk_out,
  output logic            rise,
  output logic            fall
);
  logic [7:0] cnt;

  // Toggles the output every half_cycles clocks and flags each edge.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt     <= 8'h00;
      clk_out <= 1'b0;
      rise    <= 1'b0;
      fall    <= 1'b0;
    end
    else if (cnt >= half_cycles - 8'h01)
    begin
      cnt     <= 8'h00;
      clk_out <= ~clk_out;
      rise    <= ~clk_out;
      fall    <= clk_out;
    end
    else
    begin
      cnt  <= cnt + 8'h01;
      rise <= 1'b0;
      fall <= 1'b0;
    end
  end
endmodule

// ---- verilog/pmx_fifo.sv ----
`timescale 1ns/1ps
module pmx_fifo
  import pmx_pkg::*;
#(
  parameter int W     = NIB_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (in_valid && in_ready)
    begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (in_valid && in_ready)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_valid && out_ready)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

// ---- verilog/pmx_core.sv ----
// Contract
// - In 10M full duplex, transmit data is never echoed onto the receive path.
// - In 10M full duplex, the heartbeat collision pulse after a frame is suppressed.
// - Full duplex: carrier sense follows receive activity only; collision stays low.
// - Half duplex: carrier sense is high while transmitting or receiving.
// - Half duplex: collision is high when receiving during a transmission.
// - Crossover enabled and no link: transmit and receive pairs are swapped automatically.
// - Crossover defaults on; a strap pin or register 19 bit 8 disables it.
// - Crossover resolves on its own and before auto-negotiation may start.
// - Frame data crosses the MAC side as framed 4-bit nibbles at both speeds.
// - The device generates both nibble clocks; the MAC never drives them.
// - There is no transmit-error input from the MAC.
// - Receive nibbles leave qualified by their valid flag, timed to RXCLK.
// - During power-on reset the MII and pair drivers are isolated, enabled after.
// - Management uses a clock from the station and one two-way data line.
// - The management pins work in every speed and duplex mode.
// - A consolidated status register gives the main link status in one read.
// - Nibble clocks run at 25 MHz at 100M and 2.5 MHz at 10M.
`timescale 1ns/1ps
module pmx_core
  import pmx_pkg::*;
#(
  parameter int         SWAP_CYC = SWAP_CYCLES,
  parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEF
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] mac_txd,
  input  wire logic       mac_txen,
  output logic            mii_txclk,
  output logic            mii_rxclk,
  output logic [3:0]      mii_rxd,
  output logic            mii_rxdv,
  output logic            mii_crs,
  output logic            mii_col,
  output logic            mii_oe,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic       crossover_enable_strap,
  input  wire logic [3:0] line_rx_nibble,
  input  wire logic       line_rx_strobe,
  input  wire logic       line_rx_active,
  input  wire logic       line_energy,
  input  wire logic       line_link_up,
  input  wire logic       line_speed_100,
  input  wire logic       line_full_duplex,
  output logic [3:0]      line_tx_nibble,
  output logic            line_tx_valid,
  input  wire logic       line_tx_ready,
  output logic            tx_buf_ready,
  output logic            pair_swap,
  output logic            pair_tx_oe,
  output logic            aneg_go
);
  logic [1:0]  sync_a [8];
  logic [7:0]  pin_raw;
  logic [3:0]  txd_s;
  logic        txen_s;
  logic        mdc_s;
  logic        mdio_s;
  logic        strap_s;
  logic        mdc_q;
  logic        mdc_rise;
  logic        nclk;
  logic        nrise;
  logic        nfall;
  logic        tx_active;
  logic [3:0]  tx_nib;
  logic [3:0]  rx_hold;
  logic        echo;
  logic [3:0]  sqe_cnt;
  logic        strap_lat;
  logic        strap_done;
  logic [1:0]  xctl;
  logic        auto_en;
  pmx_xo_st_t  xo_st;
  logic [31:0] swap_cnt;
  pmx_md_st_t  md_st;
  logic [5:0]  pre_cnt;
  logic [4:0]  bit_cnt;
  logic [12:0] hdr;
  logic [15:0] sh;
  logic        ta_seen;
  logic [15:0] rd_data;

  // Pins from outside the clock domain pass two flip-flops.
  assign pin_raw = {crossover_enable_strap, mdio_in, mdc, mac_txen, mac_txd};
  for (genvar i = 0; i < 8; i++)
  begin : g_sync
    always_ff @(posedge clk)
    begin
      sync_a[i] <= {sync_a[i][0], pin_raw[i]};
    end
  end
  assign txd_s   = {sync_a[3][1], sync_a[2][1], sync_a[1][1], sync_a[0][1]};
  assign txen_s  = sync_a[4][1];
  assign mdc_s   = sync_a[5][1];
  assign mdio_s  = sync_a[6][1];
  assign strap_s = sync_a[7][1];

  // One divider sources both nibble clocks at the selected rate.
  pmx_clkdiv u_div (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .half_cycles (line_speed_100 ? HALF_100 : HALF_10),
    .clk_out     (nclk),
    .rise        (nrise),
    .fall        (nfall)
  );
  assign mii_txclk = nclk;
  assign mii_rxclk = nclk;

  // Drivers stay off while reset is held and turn on after it.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mii_oe     <= 1'b0;
      pair_tx_oe <= 1'b0;
    end
    else
    begin
      mii_oe     <= 1'b1;
      pair_tx_oe <= 1'b1;
    end
  end

  // Transmit nibbles are taken mid-period, away from the MAC's change after the rise; no error input exists.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      tx_active <= 1'b0;
      tx_nib    <= 4'h0;
    end
    else if (nfall)
    begin
      tx_active <= txen_s;
      tx_nib    <= txd_s;
    end
  end

  pmx_fifo #(
    .W     (NIB_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (nfall && txen_s),
    .in_ready  (tx_buf_ready),
    .in_data   (txd_s),
    .out_valid (line_tx_valid),
    .out_ready (line_tx_ready),
    .out_data  (line_tx_nibble)
  );

  // Echo of transmit onto receive happens only in 10M half duplex.
  assign echo = !line_speed_100 && !line_full_duplex && tx_active && !line_rx_active;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rx_hold <= 4'h0;
    end
    else if (line_rx_strobe)
    begin
      rx_hold <= line_rx_nibble;
    end
  end

  // Receive outputs change on the clock fall so the MAC samples them stable on the rise.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mii_rxd  <= 4'h0;
      mii_rxdv <= 1'b0;
    end
    else if (nfall)
    begin
      mii_rxd  <= echo ? tx_nib : rx_hold;
      mii_rxdv <= echo ? 1'b1 : line_rx_active;
    end
  end

  // Heartbeat pulse after a 10M half-duplex frame.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      sqe_cnt <= 4'h0;
    end
    else if (nfall && tx_active && !txen_s && !line_speed_100 && !line_full_duplex)
    begin
      sqe_cnt <= SQE_NIBBLES;
    end
    else if (line_full_duplex)
    begin
      sqe_cnt <= 4'h0;
    end
    else if (nrise && sqe_cnt != 4'h0)
    begin
      sqe_cnt <= sqe_cnt - 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mii_crs <= 1'b0;
      mii_col <= 1'b0;
    end
    else if (line_full_duplex)
    begin
      mii_crs <= line_rx_active;
      mii_col <= 1'b0;
    end
    else
    begin
      mii_crs <= tx_active || line_rx_active;
      mii_col <= (tx_active && line_rx_active) || sqe_cnt != 4'h0;
    end
  end

  // The strap is caught once, on the first cycle after reset release.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      strap_lat  <= 1'b1;
      strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_lat  <= strap_s;
      strap_done <= 1'b1;
    end
  end

  assign auto_en = strap_lat && xctl[0];

  // Crossover hunt runs ahead of negotiation, independent of it.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      xo_st     <= XO_HUNT;
      swap_cnt  <= 32'h0;
      pair_swap <= 1'b0;
    end
    else if (!auto_en)
    begin
      xo_st     <= XO_LOCK;
      swap_cnt  <= 32'h0;
      pair_swap <= xctl[1];
    end
    else
    begin
      case (xo_st)
        XO_HUNT:
        begin
          if (line_energy)
          begin
            xo_st    <= XO_LOCK;
            swap_cnt <= 32'h0;
          end
          else if (swap_cnt >= 32'(SWAP_CYC - 1))
          begin
            swap_cnt  <= 32'h0;
            pair_swap <= ~pair_swap;
          end
          else
          begin
            swap_cnt <= swap_cnt + 32'h1;
          end
        end
        XO_LOCK:
        begin
          if (!line_link_up && !line_energy)
          begin
            xo_st <= XO_HUNT;
          end
        end
        default:
        begin
          xo_st <= XO_HUNT;
        end
      endcase
    end
  end
  assign aneg_go = strap_done && (xo_st == XO_LOCK);

  // Management slave; it ignores speed, duplex and isolation.
  always_ff @(posedge clk)
  begin
    mdc_q <= mdc_s;
  end
  assign mdc_rise = mdc_s && !mdc_q;

  always_comb
  begin
    rd_data = 16'h0000;
    if (hdr[4:0] == REG_XCTL)
    begin
      rd_data[XCTL_MAN_BIT:XCTL_AUTO_BIT] = xctl;
    end
    else if (hdr[4:0] == REG_CSTAT)
    begin
      rd_data[5:0] = {aneg_go, pair_swap, auto_en, line_full_duplex, line_speed_100, line_link_up};
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      md_st    <= MD_PRE;
      pre_cnt  <= 6'h00;
      bit_cnt  <= 5'h00;
      hdr      <= 13'h0000;
      sh       <= 16'h0000;
      ta_seen  <= 1'b0;
      mdio_out <= 1'b0;
      mdio_oe  <= 1'b0;
      xctl     <= XCTL_RST;
    end
    else if (mdc_rise)
    begin
      case (md_st)
        MD_PRE:
        begin
          if (mdio_s)
          begin
            pre_cnt <= (pre_cnt == PRE_BITS) ? pre_cnt : pre_cnt + 6'h01;
          end
          else
          begin
            pre_cnt <= 6'h00;
            bit_cnt <= 5'h00;
            md_st   <= (pre_cnt == PRE_BITS) ? MD_HDR : MD_PRE;
          end
        end
        MD_HDR:
        begin
          hdr     <= {hdr[11:0], mdio_s};
          bit_cnt <= bit_cnt + 5'h01;
          ta_seen <= 1'b0;
          if (bit_cnt == HDR_BITS - 5'h01)
          begin
            if (hdr[11] && hdr[8:4] == PHY_ADDR &&
                (hdr[10:9] == OP_RD || hdr[10:9] == OP_WR))
            begin
              md_st <= MD_TA;
            end
            else
            begin
              md_st <= MD_PRE;
            end
          end
        end
        MD_TA:
        begin
          bit_cnt <= 5'h00;
          if (hdr[11:10] == OP_RD)
          begin
            mdio_oe  <= 1'b1;
            mdio_out <= 1'b0;
            sh       <= rd_data;
            md_st    <= MD_RD;
          end
          else if (hdr[11:10] == OP_WR && ta_seen)
          begin
            md_st <= MD_WR;
          end
          else if (hdr[11:10] == OP_WR)
          begin
            ta_seen <= 1'b1;
          end
          else
          begin
            md_st <= MD_PRE;
          end
        end
        MD_RD:
        begin
          if (bit_cnt == DATA_BITS)
          begin
            mdio_oe <= 1'b0;
            pre_cnt <= 6'h00;
            md_st   <= MD_PRE;
          end
          else
          begin
            mdio_out <= sh[15];
            sh       <= {sh[14:0], 1'b0};
            bit_cnt  <= bit_cnt + 5'h01;
          end
        end
        MD_WR:
        begin
          sh      <= {sh[14:0], mdio_s};
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == DATA_BITS - 5'h01)
          begin
            if (hdr[4:0] == REG_XCTL)
            begin
              xctl <= {sh[XCTL_MAN_BIT-1], sh[XCTL_AUTO_BIT-1]};
            end
            pre_cnt <= 6'h00;
            md_st   <= MD_PRE;
          end
        end
        default:
        begin
          md_st <= MD_PRE;
        end
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_fd_no_echo;
    nfall && line_full_duplex && !line_rx_active |=> !mii_rxdv;
  endproperty
  a_fd_no_echo: assert property (p_fd_no_echo) else $error("echo seen in full duplex");

  property p_fd_no_sqe;
    line_full_duplex |=> sqe_cnt == 4'h0;
  endproperty
  a_fd_no_sqe: assert property (p_fd_no_sqe) else $error("heartbeat armed in full duplex");

  property p_fd_crs_col;
    line_full_duplex |=> !mii_col && mii_crs == $past(line_rx_active);
  endproperty
  a_fd_crs_col: assert property (p_fd_crs_col) else $error("full duplex carrier or collision wrong");

  property p_hd_crs;
    !line_full_duplex && (tx_active || line_rx_active) |=> mii_crs;
  endproperty
  a_hd_crs: assert property (p_hd_crs) else $error("half duplex carrier missing");

  property p_hd_col;
    !line_full_duplex && tx_active && line_rx_active |=> mii_col;
  endproperty
  a_hd_col: assert property (p_hd_col) else $error("half duplex collision missing");

  property p_hunt_swap;
    auto_en && xo_st == XO_HUNT && !line_energy && swap_cnt >= 32'(SWAP_CYC - 1) |=> pair_swap != $past(pair_swap);
  endproperty
  a_hunt_swap: assert property (p_hunt_swap) else $error("pair swap did not toggle");

  property p_aneg_after_xo;
    auto_en && $rose(aneg_go) |-> $past(line_energy) || $past(xo_st) == XO_LOCK;
  endproperty
  a_aneg_after_xo: assert property (p_aneg_after_xo) else $error("negotiation before crossover");

  property p_clk_runs;
    $rose(mii_txclk) |-> ##[1:60] $fell(mii_txclk);
  endproperty
  a_clk_runs: assert property (p_clk_runs) else $error("nibble clock stalled");

  property p_clk_100;
    $rose(mii_txclk) && line_speed_100 && $past(line_speed_100) ##1 line_speed_100[*5] |-> !mii_txclk;
  endproperty
  a_clk_100: assert property (p_clk_100) else $error("100M nibble clock period wrong");

  property p_rx_qual;
    nfall && !echo |=> mii_rxdv == $past(line_rx_active) && mii_rxd == $past(rx_hold);
  endproperty
  a_rx_qual: assert property (p_rx_qual) else $error("receive nibble not qualified");

  property p_iso;
    disable iff (1'b0) sys_rst |=> !mii_oe && !pair_tx_oe;
  endproperty
  a_iso: assert property (p_iso) else $error("drivers enabled during reset");
endmodule

// ---- bench/pmx_mac_model.sv ----
`timescale 1ns/1ps
module pmx_mac_model
  import pmx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       mii_txclk,
  input  wire logic       tx_req,
  input  wire logic [3:0] tx_nib,
  output logic [3:0]      mac_txd,
  output logic            mac_txen,
  output logic            tx_took
);
  logic txclk_q;

  // The MAC only follows the clock that the device makes; there is no error output.
  always @(posedge clk)
  begin
    txclk_q <= mii_txclk;
    tx_took <= 1'b0;
    if (sys_rst)
    begin
      mac_txen <= 1'b0;
      mac_txd  <= 4'h0;
    end
    else if (mii_txclk && !txclk_q)
    begin
      mac_txen <= tx_req;
      tx_took  <= tx_req;
      mac_txd  <= tx_req ? tx_nib : ~mac_txd;
    end
  end
endmodule

// ---- bench/pmx_core_tb.sv ----
`timescale 1ns/1ps
module pmx_core_tb
  import pmx_pkg::*;
;
  localparam int SWAP = 20;
  logic        clk, sys_rst, mac_txen, mii_txclk, mii_rxclk, mii_rxdv, mii_crs, mii_col, mii_oe;
  logic        mdc, mdio_in, mdio_out, mdio_oe, strap, line_energy;
  logic        line_link_up, line_speed_100, line_full_duplex, line_tx_valid;
  logic        tx_buf_ready, pair_swap, pair_tx_oe, aneg_go, tx_req, tx_took, rx_on, sta_oe, sta_bit;
  logic        hold, s;
  logic        line_rx_strobe = 1'b0;
  logic        line_rx_active = 1'b0;
  logic        line_tx_ready  = 1'b0;
  logic        txclk_q        = 1'b0;
  logic        rxclk_q        = 1'b0;
  logic [3:0]  mac_txd, mii_rxd, line_tx_nibble;
  logic [3:0]  line_rx_nibble = 4'h0;
  logic [3:0]  tx_nib         = 4'h0;
  logic [3:0]  txq[$], rxq[$];
  logic [15:0] rd;
  logic [31:0] lfsr = 32'h850bc0c3;
  int          err_count, checks, echo_cnt, col_cnt, nrise, e0, c0, n;
  time         t0;

  assign mdio_in = mdio_oe ? mdio_out : (sta_oe ? sta_bit : 1'b1);

  pmx_core #(.SWAP_CYC(SWAP)) u_pmx_core (.clk(clk), .sys_rst(sys_rst), .mac_txd(mac_txd),
    .mac_txen(mac_txen), .mii_txclk(mii_txclk), .mii_rxclk(mii_rxclk), .mii_rxd(mii_rxd),
    .mii_rxdv(mii_rxdv), .mii_crs(mii_crs), .mii_col(mii_col), .mii_oe(mii_oe), .mdc(mdc),
    .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .crossover_enable_strap(strap),
    .line_rx_nibble(line_rx_nibble), .line_rx_strobe(line_rx_strobe), .line_rx_active(line_rx_active),
    .line_energy(line_energy), .line_link_up(line_link_up), .line_speed_100(line_speed_100),
    .line_full_duplex(line_full_duplex), .line_tx_nibble(line_tx_nibble), .line_tx_valid(line_tx_valid),
    .line_tx_ready(line_tx_ready), .tx_buf_ready(tx_buf_ready), .pair_swap(pair_swap),
    .pair_tx_oe(pair_tx_oe), .aneg_go(aneg_go));

  pmx_mac_model u_pmx_mac_model (.clk(clk), .sys_rst(sys_rst), .mii_txclk(mii_txclk), .tx_req(tx_req),
    .tx_nib(tx_nib), .mac_txd(mac_txd), .mac_txen(mac_txen), .tx_took(tx_took));

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic rises(input int k);
    int t;
    t = nrise + k;
    while (nrise < t)
    begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic do_reset(input logic st);
    sys_rst <= 1'b1;
    strap   <= st;
    repeat (3) @(posedge clk);
    #1;
    cmp(16'({mii_oe, pair_tx_oe}), 16'h0);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    cmp(16'({mii_oe, pair_tx_oe}), 16'h3);
  endtask

  task automatic md_xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
    logic [31:0] f;
    f = {2'b01, op, PHY_ADDR_DEF, ra, 2'b10, wd};
    sta_oe = 1'b1;
    for (int i = 63; i >= 0; i--)
    begin
      if (i == 17 && op == OP_RD)
        sta_oe = 1'b0;
      sta_bit = (i > 31) ? 1'b1 : f[i];
      #62.5;
      if (i < 16)
        rd[i] = mdio_in;
      mdc = 1'b1;
      #62.5;
      mdc = 1'b0;
    end
    sta_oe = 1'b0;
  endtask

  always @(posedge clk)
  begin
    txclk_q        <= mii_txclk;
    rxclk_q        <= mii_rxclk;
    lfsr           <= nxt(lfsr);
    line_tx_ready  <= !hold && lfsr[3];
    line_rx_strobe <= 1'b0;
    if (mii_col)
      col_cnt++;
    if (tx_took)
    begin
      if (txq.size() < FIFO_DEPTH)
        txq.push_back(mac_txd);
      tx_nib <= lfsr[7:4];
    end
    if (line_tx_valid && line_tx_ready)
    begin
      cmp(16'(txq.size() != 0), 16'h1);
      if (txq.size() != 0)
        cmp(16'(line_tx_nibble), 16'(txq.pop_front()));
    end
    if (mii_txclk && !txclk_q)
      nrise++;
    if (mii_rxclk && !rxclk_q)
    begin
      if (rxq.size() != 0)
        cmp(16'({mii_rxdv, mii_rxd}), 16'({1'b1, rxq.pop_front()}));
      else if (mii_rxdv)
        echo_cnt++;
      line_rx_active <= rx_on;
      line_rx_strobe <= rx_on;
      line_rx_nibble <= lfsr[11:8];
      if (rx_on)
        rxq.push_back(lfsr[11:8]);
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial
  begin
    #300000;
    err_count++;
    end_sim();
  end

  initial
  begin
    {sys_rst, strap, mdc, sta_oe, sta_bit, line_energy} = 6'h20;
    {line_link_up, line_full_duplex, tx_req, rx_on, hold} = 5'h0;
    line_speed_100 = 1'b1;
    do_reset(1'b1);
    md_xfer(OP_RD, REG_XCTL, 16'h0);
    cmp(rd, {6'h0, XCTL_RST, 8'h0});
    s = pair_swap;
    n = 0;
    while (pair_swap === s && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    s = pair_swap;
    n = 0;
    while (pair_swap === s && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    cmp(16'(n), 16'(SWAP));
    cmp(16'(aneg_go), 16'h0);
    line_energy  <= 1'b1;
    line_link_up <= 1'b1;
    repeat (5) @(posedge clk);
    s = pair_swap;
    repeat (3 * SWAP) @(posedge clk);
    cmp(16'({pair_swap, aneg_go}), 16'({s, 1'b1}));
    md_xfer(OP_RD, REG_CSTAT, 16'h0);
    cmp(rd, {10'h0, 1'b1, s, 4'b1011});
    line_energy  <= 1'b0;
    line_link_up <= 1'b0;
    md_xfer(OP_WR, REG_XCTL, 16'h0200);
    repeat (3 * SWAP) @(posedge clk);
    cmp(16'(pair_swap), 16'h1);
    md_xfer(OP_WR, REG_XCTL, 16'h0000);
    repeat (3 * SWAP) @(posedge clk);
    cmp(16'(pair_swap), 16'h0);
    do_reset(1'b0);
    repeat (3 * SWAP) @(posedge clk);
    cmp(16'(pair_swap), 16'h0);
    md_xfer(OP_RD, REG_CSTAT, 16'h0);
    cmp(16'(rd[3]), 16'h0);
    $display("crossover and management test done");
    line_energy  <= 1'b1;
    line_link_up <= 1'b1;
    do_reset(1'b1);
    for (int m = 0; m < 4; m++)
    begin
      line_speed_100   <= m[0];
      line_full_duplex <= m[1];
      rises(3);
      t0 = $time;
      rises(1);
      cmp(16'(($time - t0) / 4), m[0] ? 16'(2 * HALF_100) : 16'(2 * HALF_10));
      cmp(16'(mii_rxclk), 16'(mii_txclk));
      e0 = echo_cnt;
      tx_req <= 1'b1;
      rises(6);
      cmp(16'({mii_crs, mii_col}), 16'({!m[1], 1'b0}));
      cmp(16'(echo_cnt != e0), 16'(!m[0] && !m[1]));
      rx_on <= 1'b1;
      rises(6);
      cmp(16'({mii_crs, mii_col}), 16'({1'b1, !m[1]}));
      rx_on <= 1'b0;
      rises(4);
      tx_req <= 1'b0;
      rises(1);
      c0 = col_cnt;
      rises(14);
      cmp(16'(col_cnt != c0), 16'(!m[0] && !m[1]));
      md_xfer(OP_RD, REG_XCTL, 16'h0);
      cmp(rd, 16'h0100);
      $display("mode %0d test done", m);
    end
    line_speed_100 <= 1'b1;
    hold   <= 1'b1;
    tx_req <= 1'b1;
    rises(40);
    cmp(16'({tx_buf_ready, 6'(txq.size())}), 16'(FIFO_DEPTH));
    tx_req <= 1'b0;
    rises(1);
    hold   <= 1'b0;
    rises(50);
    cmp(16'({line_tx_valid, 6'(txq.size())}), 16'h0);
    $display("buffer test done");
    end_sim();
  end
endmodule
